// [uarx_receiver.sv]
`timescale 1ns/100ps
`default_nettype none

`include "uarx_defs.svh"

module uarx_receiver
   import uarx_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        reset_i,
   // Serial inputs
   input  wire logic        rx_pin0_i,
   input  wire logic        rx_pin1_i,
   // Register port
   input  wire logic [2:0]  reg_addr_i,
   input  wire logic [15:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [15:0] reg_rdata_o,
   // Interrupt
   output logic             irq_o
);

   uarx_state_t state_r;
   uarx_state_t state_nxt;
   logic [1:0]  ctrl_r;
   logic [1:0]  ctrl_nxt;
   logic [7:0]  cfg_r;
   logic [7:0]  cfg_nxt;
   logic [12:0] baud_r;
   logic [12:0] baud_nxt;
   logic [7:0]  shift_r;
   logic [7:0]  shift_nxt;
   logic [7:0]  rx_buf_r;
   logic [7:0]  rx_buf_nxt;
   logic        buf_full_r;
   logic        buf_full_nxt;
   logic [2:0]  idx_r;
   logic [2:0]  idx_nxt;
   logic        par_bit_r;
   logic        par_bit_nxt;
   logic        start_bad_r;
   logic        start_bad_nxt;
   logic [2:0]  err_r;
   logic [2:0]  err_nxt;
   logic [1:0]  istat_r;
   logic [1:0]  istat_nxt;
   logic [1:0]  imask_r;
   logic [1:0]  imask_nxt;
   logic [15:0] rdata_r;
   logic [15:0] rdata_nxt;
   logic        irq_r;
   logic        irq_nxt;

   logic        enable;
   logic        line;
   logic        restart;
   logic        mid_tick;
   logic        end_tick;
   logic        load;
   logic        check;
   logic        wr_err;
   logic        rd_buf;
   logic [2:0]  last_bit;
   logic [2:0]  err_set;
   logic [1:0]  ev_set;

   // Bit clock generator runs on the system clock
   uarx_baud u_baud (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .run_i     (enable && state_r != UARX_IDLE),
      .restart_i (restart),
      .count_i   (baud_r),
      .shift_i   (cfg_r[`UARX_CFG_SHIFT]),
      .mid_o     (mid_tick),
      .end_o     (end_tick)
   );

   always_comb begin
      enable   = ctrl_r[`UARX_CTL_ENABLE];
      last_bit = uarx_last_bit(cfg_r[`UARX_CFG_LEN_HI:`UARX_CFG_LEN_LO]);
      line = (ctrl_r[`UARX_CTL_PINSEL] ? rx_pin1_i : rx_pin0_i)
             ^ cfg_r[`UARX_CFG_NEG_LOGIC];
      wr_err  = reg_wr_i && (reg_addr_i == `UARX_OFS_ERRSTAT);
      rd_buf  = reg_rd_i && (reg_addr_i == `UARX_OFS_BUFFER);
      restart = 1'b0;
      load    = 1'b0;
      check   = 1'b0;
      err_set = 3'h0;

      state_nxt     = state_r;
      shift_nxt     = shift_r;
      rx_buf_nxt    = rx_buf_r;
      idx_nxt       = idx_r;
      par_bit_nxt   = par_bit_r;
      start_bad_nxt = start_bad_r;

      case (state_r)
         UARX_IDLE: begin
            if (enable && !line) begin
               restart       = 1'b1;
               state_nxt     = UARX_START;
               shift_nxt     = 8'h00;
               idx_nxt       = 3'h0;
               start_bad_nxt = 1'b0;
            end
         end
         UARX_START: begin
            // Confirm start level at bit centre
            if (mid_tick) begin
               start_bad_nxt = line;
            end
            if (end_tick) begin
               state_nxt = UARX_DATA;
            end
         end
         UARX_DATA: begin
            if (mid_tick) begin
               if (cfg_r[`UARX_CFG_MSB_FIRST]) begin
                  shift_nxt = {shift_r[6:0], line};
               end else begin
                  shift_nxt[idx_r] = line;
               end
            end
            if (end_tick) begin
               if (idx_r != last_bit) begin
                  idx_nxt = idx_r + 3'h1;
               end else if (cfg_r[`UARX_CFG_PAR_EN]) begin
                  state_nxt = UARX_PARITY;
               end else begin
                  load      = 1'b1;
                  state_nxt = UARX_STOP1;
               end
            end
         end
         UARX_PARITY: begin
            if (mid_tick) begin
               par_bit_nxt = line;
            end
            if (end_tick) begin
               load      = 1'b1;
               state_nxt = UARX_STOP1;
            end
         end
         UARX_STOP1: begin
            // Checks at first bit centre (mid tick) after load
            if (mid_tick) begin
               check = 1'b1;
               err_set[`UARX_ERR_FRAMING] = !line || start_bad_r;
               err_set[`UARX_ERR_PARITY]  = cfg_r[`UARX_CFG_PAR_EN]
                  && ((^shift_r) ^ par_bit_r ^ cfg_r[`UARX_CFG_PAR_ODD]);
               // Next frame follows without software help
               state_nxt = cfg_r[`UARX_CFG_STOP2] ? UARX_STOP2 : UARX_IDLE;
            end
         end
         UARX_STOP2: begin
            if (mid_tick) begin
               err_set[`UARX_ERR_FRAMING] = !line;
               state_nxt = UARX_IDLE;
            end
         end
         default: begin
            state_nxt = UARX_IDLE;
         end
      endcase

      // Word to buffer, upper bits zero
      if (load) begin
         rx_buf_nxt = shift_r;
      end
      err_set[`UARX_ERR_OVERRUN] = load && buf_full_r;
      buf_full_nxt = load ? 1'b1 : (rd_buf ? 1'b0 : buf_full_r);

      if (!enable) begin
         state_nxt = UARX_IDLE;
      end

      ctrl_nxt  = ctrl_r;
      cfg_nxt   = cfg_r;
      baud_nxt  = baud_r;
      imask_nxt = imask_r;
      ev_set    = {|err_set, check};
      istat_nxt = istat_r;
      if (reg_wr_i) begin
         case (reg_addr_i)
            `UARX_OFS_CONTROL: ctrl_nxt = reg_wdata_i[1:0];
            `UARX_OFS_CONFIG:  cfg_nxt  = reg_wdata_i[7:0];
            `UARX_OFS_BAUD: begin
               // Count limited to the largest count
               if (reg_wdata_i[12:0] > `UARX_BAUD_MAX) begin
                  baud_nxt = `UARX_BAUD_MAX;
               end else begin
                  baud_nxt = reg_wdata_i[12:0];
               end
            end
            `UARX_OFS_IRQSTAT: istat_nxt = istat_r & ~reg_wdata_i[1:0];
            `UARX_OFS_IRQMASK: imask_nxt = reg_wdata_i[1:0];
            default: begin
            end
         endcase
      end
      istat_nxt = istat_nxt | ev_set;
      // Any write clears, new errors win
      err_nxt = (wr_err ? 3'h0 : err_r) | err_set;
      irq_nxt = |(istat_nxt & imask_nxt);

      rdata_nxt = 16'h0000;
      if (reg_rd_i) begin
         case (reg_addr_i)
            `UARX_OFS_CONTROL: rdata_nxt = {14'h0000, ctrl_r};
            `UARX_OFS_CONFIG:  rdata_nxt = {8'h00, cfg_r};
            `UARX_OFS_BAUD:    rdata_nxt = {3'h0, baud_r};
            `UARX_OFS_BUFFER:  rdata_nxt = {7'h00, buf_full_r, rx_buf_r};
            `UARX_OFS_ERRSTAT: rdata_nxt = {13'h0000, err_r};
            `UARX_OFS_IRQSTAT: rdata_nxt = {14'h0000, istat_r};
            `UARX_OFS_IRQMASK: rdata_nxt = {14'h0000, imask_r};
            default:           rdata_nxt = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         state_r     <= UARX_IDLE;
         ctrl_r      <= `UARX_RST_CONTROL;
         cfg_r       <= `UARX_RST_CONFIG;
         baud_r      <= `UARX_RST_BAUD;
         shift_r     <= 8'h00;
         rx_buf_r    <= 8'h00;
         buf_full_r  <= 1'b0;
         idx_r       <= 3'h0;
         par_bit_r   <= 1'b0;
         start_bad_r <= 1'b0;
         err_r       <= 3'h0;
         istat_r     <= 2'h0;
         imask_r     <= 2'h0;
         rdata_r     <= 16'h0000;
         irq_r       <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         ctrl_r      <= ctrl_nxt;
         cfg_r       <= cfg_nxt;
         baud_r      <= baud_nxt;
         shift_r     <= shift_nxt;
         rx_buf_r    <= rx_buf_nxt;
         buf_full_r  <= buf_full_nxt;
         idx_r       <= idx_nxt;
         par_bit_r   <= par_bit_nxt;
         start_bad_r <= start_bad_nxt;
         err_r       <= err_nxt;
         istat_r     <= istat_nxt;
         imask_r     <= imask_nxt;
         rdata_r     <= rdata_nxt;
         irq_r       <= irq_nxt;
      end
   end

   assign reg_rdata_o = rdata_r;
   assign irq_o       = irq_r;

   a_idle_when_off: assert property (@(posedge clk_sys_i)
      disable iff (reset_i) !enable |=> state_r == UARX_IDLE)
      else $error("receiver active while disabled");

   a_start_detect: assert property (@(posedge clk_sys_i)
      disable iff (reset_i) state_r == UARX_IDLE && enable && !line
      && ctrl_nxt[0] |=> state_r == UARX_START)
      else $error("start bit not detected");

   a_buf_load: assert property (@(posedge clk_sys_i)
      disable iff (reset_i) load |=> buf_full_r && rx_buf_r == $past(shift_r))
      else $error("word not moved to buffer");

   a_overrun_set: assert property (@(posedge clk_sys_i)
      disable iff (reset_i) load && buf_full_r |=> err_r[`UARX_ERR_OVERRUN])
      else $error("overrun not flagged");

   a_err_clear: assert property (@(posedge clk_sys_i)
      disable iff (reset_i) wr_err && err_set == 3'h0 |=> err_r == 3'h0)
      else $error("error flags not cleared by write");

   a_rx_event: assert property (@(posedge clk_sys_i)
      disable iff (reset_i) check |=> istat_r[`UARX_IRQ_RX])
      else $error("reception event missing");

   a_unused_zero: assert property (@(posedge clk_sys_i)
      disable iff (reset_i) load && $stable(cfg_r)
      |=> (rx_buf_r >> ({1'b0, last_bit} + 4'h1)) == 8'h00)
      else $error("unused buffer bits not zero");

   a_irq_level: assert property (@(posedge clk_sys_i)
      disable iff (reset_i) ##1 irq_o == |(istat_r & imask_r))
      else $error("interrupt level wrong");

   a_read_window: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      !reg_rd_i |=> reg_rdata_o == 16'h0000)
      else $error("read data outside read window");

endmodule

`default_nettype wire

// [uarx_defs.svh]
`ifndef UARX_DEFS_SVH
`define UARX_DEFS_SVH

// Register indexes on the plain register port
`define UARX_ADDR_W          3
`define UARX_DATA_W          16
`define UARX_OFS_CONTROL     3'h0
`define UARX_OFS_CONFIG      3'h1
`define UARX_OFS_BAUD        3'h2
`define UARX_OFS_BUFFER      3'h3
`define UARX_OFS_ERRSTAT     3'h4
`define UARX_OFS_IRQSTAT     3'h5
`define UARX_OFS_IRQMASK     3'h6

// serial_control_reg fields
`define UARX_CTL_ENABLE      0
`define UARX_CTL_PINSEL      1

// frame_format_reg fields
`define UARX_CFG_LEN_LO      0
`define UARX_CFG_LEN_HI      1
`define UARX_CFG_PAR_EN      2
`define UARX_CFG_PAR_ODD     3
`define UARX_CFG_STOP2       4
`define UARX_CFG_MSB_FIRST   5
`define UARX_CFG_NEG_LOGIC   6
`define UARX_CFG_SHIFT       7

// rx_error_status_reg fields
`define UARX_ERR_FRAMING     0
`define UARX_ERR_OVERRUN     1
`define UARX_ERR_PARITY      2

// Interrupt status and mask fields
`define UARX_IRQ_RX          0
`define UARX_IRQ_ERR         1

// Reset values, widths and baud count limit
`define UARX_BAUD_W          13
`define UARX_BAUD_MAX        13'h1000
`define UARX_RST_BAUD        13'h0000
`define UARX_RST_CONTROL     2'h0
`define UARX_RST_CONFIG      8'h00

`endif

// [uarx_pkg.sv]
package uarx_pkg;

   typedef enum logic [2:0] {
      UARX_IDLE   = 3'h0,
      UARX_START  = 3'h1,
      UARX_DATA   = 3'h3,
      UARX_PARITY = 3'h2,
      UARX_STOP1  = 3'h6,
      UARX_STOP2  = 3'h7
   } uarx_state_t;

   // Index of the last data bit for a character length code (5..8 bits)
   function automatic logic [2:0] uarx_last_bit(input logic [1:0] len);
      uarx_last_bit = 3'h4 + {1'b0, len};
   endfunction

endpackage

// [uarx_baud.sv]
`timescale 1ns/100ps
`default_nettype none

module uarx_baud
   import uarx_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        reset_i,
   // Control
   input  wire logic        run_i,
   input  wire logic        restart_i,
   input  wire logic [12:0] count_i,
   input  wire logic        shift_i,
   // Transfer clock edges
   output logic             mid_o,
   output logic             end_o
);

   logic [12:0] cnt_r;
   logic [12:0] cnt_nxt;
   logic        mid_r;
   logic        mid_nxt;
   logic        end_r;
   logic        end_nxt;
   logic [12:0] half;

   always_comb begin
      half = {1'b0, count_i[12:1]} + {12'h000, shift_i};
      if (half > count_i) begin
         half = count_i;
      end
      cnt_nxt = cnt_r;
      mid_nxt = 1'b0;
      end_nxt = 1'b0;
      if (!run_i || restart_i) begin
         cnt_nxt = 13'h0000;
      end else begin
         mid_nxt = (cnt_r == half);
         if (cnt_r >= count_i) begin
            cnt_nxt = 13'h0000;
            end_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r + 13'h0001;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         cnt_r <= 13'h0000;
         mid_r <= 1'b0;
         end_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         mid_r <= mid_nxt;
         end_r <= end_nxt;
      end
   end

   assign mid_o = mid_r;
   assign end_o = end_r;

   a_count_bound: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      run_i && !restart_i && $stable(count_i) |=> cnt_r <= count_i)
      else $error("baud counter passed its reload value");

endmodule

`default_nettype wire

// [uarx_tx_model.sv]
`timescale 1ns/100ps
`default_nettype none

module uarx_tx_model #(
   parameter int BIT_CLKS = 10
) (
   // Clock
   input  wire logic clk_sys_i,
   // Serial line
   output logic      line_o
);
   logic neg;

   initial begin
      neg    = 1'b0;
      line_o = 1'b1;
   end

   // Line level is inverted in negative logic, idle included
   task automatic set_neg(input logic n);
      neg = n;
      line_o <= ~n;
   endtask

   task automatic put(input logic b);
      line_o <= b ^ neg;
      repeat (BIT_CLKS) @(posedge clk_sys_i);
   endtask

   task automatic send(input logic [7:0] d, input int n, input logic msb,
                       input logic par_en, input logic par,
                       input logic stop2, input logic bad_s);
      @(posedge clk_sys_i);
      put(1'b0);
      for (int i = 0; i < n; i++) begin
         put(msb ? d[n-1-i] : d[i]);
      end
      if (par_en) begin
         put(par);
      end
      put(~bad_s);
      if (stop2) begin
         put(1'b1);
      end
      line_o <= ~neg;
   endtask
endmodule

`default_nettype wire

// [tb_uart_async_receiver.sv]
`timescale 1ns/100ps
`default_nettype none

`include "uarx_defs.svh"

module tb_uart_async_receiver;
   logic        clk_sys_i = 1'b0;
   logic        reset_i   = 1'b1;
   logic [2:0]  reg_addr_i = 3'h0;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic        reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0;
   logic [15:0] reg_rdata_o;
   logic        irq_o;
   wire logic   line;
   logic        sel = 1'b0;
   logic        neg = 1'b0;
   logic [7:0]  cfg = 8'h03;
   logic [31:0] seed = 32'h1b51_a5ef;
   logic [15:0] rv;
   int          n_errors = 0;
   int          n_compared = 0;

   always #12.5 clk_sys_i = ~clk_sys_i;

   uarx_tx_model tx (
      .clk_sys_i (clk_sys_i),
      .line_o    (line)
   );

   uarx_receiver dut (
      .clk_sys_i   (clk_sys_i),
      .reset_i     (reset_i),
      .rx_pin0_i   (sel ? ~neg : line),
      .rx_pin1_i   (sel ? line : ~neg),
      .reg_addr_i  (reg_addr_i),
      .reg_wdata_i (reg_wdata_i),
      .reg_wr_i    (reg_wr_i),
      .reg_rd_i    (reg_rd_i),
      .reg_rdata_o (reg_rdata_o),
      .irq_o       (irq_o)
   );

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   function automatic logic [7:0] masked(input logic [7:0] v,
                                         input logic [1:0] len);
      return v & (8'hff >> (2'h3 - len));
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [15:0] v);
      @(posedge clk_sys_i);
      reg_wr_i    <= 1'b1;
      reg_addr_i  <= a;
      reg_wdata_i <= v;
      @(posedge clk_sys_i);
      reg_wr_i    <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, output logic [15:0] v);
      @(posedge clk_sys_i);
      reg_rd_i   <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_sys_i);
      reg_rd_i   <= 1'b0;
      #1 v = reg_rdata_o;
   endtask

   task automatic rchk(input logic [2:0] a, input logic [15:0] exp);
      rd(a, rv);
      check(rv, exp);
   endtask

   // Sends v in the current format; returns the word the buffer must hold
   task automatic frame(input logic [7:0] v, input logic bad_p,
                        input logic bad_s, output logic [7:0] w);
      w = masked(v, cfg[1:0]);
      tx.send(w, 5 + cfg[1:0], cfg[`UARX_CFG_MSB_FIRST],
              cfg[`UARX_CFG_PAR_EN],
              (^w) ^ cfg[`UARX_CFG_PAR_ODD] ^ bad_p,
              cfg[`UARX_CFG_STOP2], bad_s);
   endtask

   // Port is stopped while format, polarity and pin change
   task automatic setup(input logic [7:0] c, input logic s);
      wr(`UARX_OFS_CONTROL, 16'h0000);
      cfg = c;
      wr(`UARX_OFS_CONFIG, {8'h00, c});
      neg <= c[`UARX_CFG_NEG_LOGIC];
      sel <= s;
      tx.set_neg(c[`UARX_CFG_NEG_LOGIC]);
      wr(`UARX_OFS_CONTROL, {14'h0000, s, 1'b1});
   endtask

   task automatic results;
      $display("errors %0d, comparisons %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge clk_sys_i);
      n_errors++;
      results();
   end

   initial begin
      logic [7:0] w;
      logic [7:0] w2;
      repeat (6) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      for (int a = 0; a < 8; a++) begin
         rchk(a[2:0], 16'h0000); // reset values, unmapped reads zero
      end
      wr(`UARX_OFS_BAUD, 16'h1fff);
      rchk(`UARX_OFS_BAUD, 16'h1000); // count clamps
      wr(`UARX_OFS_BAUD, 16'h0009);
      wr(`UARX_OFS_CONFIG, 16'h0003);
      frame(8'h55, 1'b0, 1'b0, w);
      rchk(`UARX_OFS_BUFFER, 16'h0000); // no reception when disabled
      wr(`UARX_OFS_IRQMASK, 16'h0003);
      for (int k = 0; k < 24; k++) begin
         seed = xs(seed);
         setup(seed[7:0] & 8'hef, seed[8]);
         seed = xs(seed);
         frame(seed[7:0], 1'b0, 1'b0, w);
         check({15'h0000, irq_o}, 16'h0001); // interrupt after frame
         rchk(`UARX_OFS_BUFFER, {8'h01, w}); // word
         rchk(`UARX_OFS_ERRSTAT, 16'h0000); // clean frame no flags
         rchk(`UARX_OFS_IRQSTAT, 16'h0001); // receive event
         wr(`UARX_OFS_IRQSTAT, 16'h0003);
         rchk(`UARX_OFS_IRQSTAT, 16'h0000); // status write one clear
      end
      setup(8'h93, 1'b0);
      frame(8'ha5, 1'b0, 1'b0, w);
      frame(8'h3c, 1'b0, 1'b0, w2);
      rchk(`UARX_OFS_ERRSTAT, 16'h0002); // unread overwritten
      rchk(`UARX_OFS_IRQSTAT, 16'h0003); // error event
      wr(`UARX_OFS_ERRSTAT, 16'h0000);
      rchk(`UARX_OFS_ERRSTAT, 16'h0000); // any write clears
      rchk(`UARX_OFS_BUFFER, {8'h01, w2}); // second frame kept
      // disabled only after the word is complete
      frame(8'h81, 1'b0, 1'b0, w);
      wr(`UARX_OFS_CONTROL, 16'h0000);
      wr(`UARX_OFS_CONTROL, 16'h0001);
      frame(8'h7e, 1'b0, 1'b0, w);
      rchk(`UARX_OFS_ERRSTAT, 16'h0002); // overrun across re-enable
      rchk(`UARX_OFS_BUFFER, {8'h01, w}); // buffer after re-enable
      wr(`UARX_OFS_ERRSTAT, 16'h5a5a);
      wr(`UARX_OFS_IRQSTAT, 16'h0003);
      wr(`UARX_OFS_IRQMASK, 16'h0000);
      // Five bits, odd parity, inverted line on pin 1
      setup(8'h4c, 1'b1);
      frame(8'h0f, 1'b1, 1'b0, w);
      rchk(`UARX_OFS_ERRSTAT, 16'h0004); // parity error flag
      check({15'h0000, irq_o}, 16'h0000); // masked interrupt low
      wr(`UARX_OFS_IRQMASK, 16'h0001);
      rchk(`UARX_OFS_BUFFER, {8'h01, w});
      check({15'h0000, irq_o}, 16'h0001); // unmasked interrupt high
      wr(`UARX_OFS_IRQSTAT, 16'h0001);
      rchk(`UARX_OFS_ERRSTAT, 16'h0004);
      check({15'h0000, irq_o}, 16'h0000); // cleared interrupt low
      wr(`UARX_OFS_ERRSTAT, 16'h0000);
      frame(8'hc3, 1'b0, 1'b1, w);
      rchk(`UARX_OFS_ERRSTAT, 16'h0001); // framing error flag
      rchk(`UARX_OFS_BUFFER, {8'h01, w}); // word loaded before stop
      wr(`UARX_OFS_CONTROL, 16'h0000);
      results();
   end
endmodule

`default_nettype wire
